//--- verilog/jtp_pkg.sv
// Constants, encodings and state codes for the boundary-scan test port.
// Overview of operation
// - TMS sampled on test clock rise steers states
// - Identification word bit zero is always one
// - Revision field sits in bits 31 to 28
// - Part field in bits 27 to 12, per variant
// - Maker field sits in bits 11 to 1
// - Code 0000 captures ring, selects boundary chain
// - Code 1111 selects the single bit register
// - Code 1011 loads and selects identification word
// - Code 0111 selects skip bit, floats all outputs
// - Code 0100 drives outputs from cells, skip bit
// - Code 1000 captures ring, selects boundary chain
// - Code 1100 resets core logic, selects skip bit
// - Four bit instruction register shifts TDI to TDO
// - Test logic reset loads identification read code
// - TDI taken on rising, TDO changed on falling
// - Skip bit cleared on every data capture, whatever the code
`default_nettype none
package jtp_pkg;
	// Instruction codes.
	localparam logic [3:0] JTP_IR_EXTEST   = 4'h0;
	localparam logic [3:0] JTP_IR_BYPASS   = 4'hf;
	localparam logic [3:0] JTP_IR_IDCODE   = 4'hb;
	localparam logic [3:0] JTP_IR_HIGHZ    = 4'h7;
	localparam logic [3:0] JTP_IR_CLAMP    = 4'h4;
	localparam logic [3:0] JTP_IR_SAMPLE   = 4'h8;
	localparam logic [3:0] JTP_IR_CORE_RST = 4'hc;
	// Pattern loaded into the instruction shifter on capture.
	localparam logic [3:0] JTP_IR_CAPTURE  = 4'h1;
	// Identification word fields; the values are arbitrary.
	localparam logic [3:0]  JTP_ID_REVISION = 4'h3;
	localparam logic [15:0] JTP_ID_PART_A   = 16'h5a10;
	localparam logic [15:0] JTP_ID_PART_B   = 16'h5a11;
	localparam logic [10:0] JTP_ID_MAKER    = 11'h2ab;
	localparam logic        JTP_ID_PRESENT  = 1'b1;
	// Default boundary chain length.
	localparam int unsigned JTP_CELLS_DEF = 16;
	// Register byte offsets and fields.
	localparam logic [7:0] JTP_REG_CTRL   = 8'h00;
	localparam logic [7:0] JTP_REG_STATUS = 8'h04;
	localparam int unsigned JTP_CTRL_VARIANT = 0;
	// Test port states.
	typedef enum logic [3:0] {
		JTP_TLR    = 4'b0000,
		JTP_RTI    = 4'b0001,
		JTP_SEL_DR = 4'b0010,
		JTP_CAP_DR = 4'b0011,
		JTP_SH_DR  = 4'b0100,
		JTP_EX1_DR = 4'b0101,
		JTP_PA_DR  = 4'b0110,
		JTP_EX2_DR = 4'b0111,
		JTP_UP_DR  = 4'b1000,
		JTP_SEL_IR = 4'b1001,
		JTP_CAP_IR = 4'b1010,
		JTP_SH_IR  = 4'b1011,
		JTP_EX1_IR = 4'b1100,
		JTP_PA_IR  = 4'b1101,
		JTP_EX2_IR = 4'b1110,
		JTP_UP_IR  = 4'b1111
	} jtp_st_t;
endpackage : jtp_pkg
`default_nettype wire

//--- verilog/jtp_tap.sv
// Boundary-scan test port: state machine, instruction decode and data paths.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap
	import jtp_pkg::*;
#(
	parameter int unsigned CELLS = JTP_CELLS_DEF
) (
	// Clock and reset.
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	// Test port pins.
	input  wire logic             i_tck,
	input  wire logic             i_tms,
	input  wire logic             i_tdi,
	output logic                  o_tdo,
	output logic                  o_tdo_oe_n,
	// Pin ring and functional control.
	input  wire logic [CELLS-1:0] i_pin_ring,
	output logic      [CELLS-1:0] o_cell_drive,
	output logic                  o_out_from_cells,
	output logic                  o_out_highz,
	output logic                  o_core_logic_reset,
	// Wishbone slave.
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [7:0]       i_wb_adr,
	input  wire logic [31:0]      i_wb_dat,
	input  wire logic [3:0]       i_wb_sel,
	output logic      [31:0]      o_wb_dat,
	output logic                  o_wb_ack
);

	// Whole state of the block.
	typedef struct packed {
		logic             tck_s1;
		logic             tck_s2;
		logic             tck_d;
		logic             tms_s1;
		logic             tms_s2;
		logic             tdi_s1;
		logic             tdi_s2;
		logic [CELLS-1:0] ring_s1;
		logic [CELLS-1:0] ring_s2;
		jtp_st_t          st;
		logic [3:0]       ir_sh;
		logic [3:0]       ir;
		logic             skip;
		logic [31:0]      id_sh;
		logic [CELLS-1:0] bsr_sh;
		logic [CELLS-1:0] bsr_upd;
		logic             tdo;
		logic             tdo_oe_n;
		logic             from_cells;
		logic             highz;
		logic             core_rst;
		logic             variant;
		logic             ack;
		logic [31:0]      rdat;
	} jtp_regs_t;

	jtp_regs_t q_r;
	jtp_regs_t q_nxt;

	logic tck_rise;
	logic tck_fall;
	logic wb_req;

	// Next state of the test port controller.
	function automatic jtp_st_t jtp_next(input jtp_st_t s, input logic tms);
		case (s)
			JTP_TLR:    jtp_next = tms ? JTP_TLR    : JTP_RTI;
			JTP_RTI:    jtp_next = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_DR: jtp_next = tms ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR: jtp_next = tms ? JTP_EX1_DR : JTP_SH_DR;
			JTP_SH_DR:  jtp_next = tms ? JTP_EX1_DR : JTP_SH_DR;
			JTP_EX1_DR: jtp_next = tms ? JTP_UP_DR  : JTP_PA_DR;
			JTP_PA_DR:  jtp_next = tms ? JTP_EX2_DR : JTP_PA_DR;
			JTP_EX2_DR: jtp_next = tms ? JTP_UP_DR  : JTP_SH_DR;
			JTP_UP_DR:  jtp_next = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_IR: jtp_next = tms ? JTP_TLR    : JTP_CAP_IR;
			JTP_CAP_IR: jtp_next = tms ? JTP_EX1_IR : JTP_SH_IR;
			JTP_SH_IR:  jtp_next = tms ? JTP_EX1_IR : JTP_SH_IR;
			JTP_EX1_IR: jtp_next = tms ? JTP_UP_IR  : JTP_PA_IR;
			JTP_PA_IR:  jtp_next = tms ? JTP_EX2_IR : JTP_PA_IR;
			JTP_EX2_IR: jtp_next = tms ? JTP_UP_IR  : JTP_SH_IR;
			JTP_UP_IR:  jtp_next = tms ? JTP_SEL_DR : JTP_RTI;
			default:    jtp_next = JTP_TLR;
		endcase
	endfunction : jtp_next

	// True when the instruction puts the boundary chain in the path.
	function automatic logic jtp_sel_bsr(input logic [3:0] ir);
		jtp_sel_bsr = (ir == JTP_IR_EXTEST) || (ir == JTP_IR_SAMPLE);
	endfunction : jtp_sel_bsr

	// True when the instruction puts the identification word in the path.
	function automatic logic jtp_sel_id(input logic [3:0] ir);
		jtp_sel_id = (ir == JTP_IR_IDCODE);
	endfunction : jtp_sel_id

	// Edges of the test clock, seen after the two-stage synchroniser.
	assign tck_rise = q_r.tck_s2 & ~q_r.tck_d;
	assign tck_fall = ~q_r.tck_s2 & q_r.tck_d;
	assign wb_req   = i_wb_cyc & i_wb_stb & ~q_r.ack;

	// Next-state logic for the whole block.
	always_comb begin
		q_nxt = q_r;
		// Pins come from another domain, so each passes two flip-flops.
		q_nxt.tck_s1  = i_tck;
		q_nxt.tck_s2  = q_r.tck_s1;
		q_nxt.tck_d   = q_r.tck_s2;
		q_nxt.tms_s1  = i_tms;
		q_nxt.tms_s2  = q_r.tms_s1;
		q_nxt.tdi_s1  = i_tdi;
		q_nxt.tdi_s2  = q_r.tdi_s1;
		q_nxt.ring_s1 = i_pin_ring;
		q_nxt.ring_s2 = q_r.ring_s1;

		// Rising test clock: act in the present state, then move on.
		if (tck_rise) begin
			case (q_r.st)
				JTP_CAP_DR: begin
					q_nxt.skip = 1'b0;
					if (jtp_sel_bsr(q_r.ir)) begin
						q_nxt.bsr_sh = q_r.ring_s2;
					end
					if (jtp_sel_id(q_r.ir)) begin
						q_nxt.id_sh = {JTP_ID_REVISION,
							q_r.variant ? JTP_ID_PART_B : JTP_ID_PART_A,
							JTP_ID_MAKER,
							JTP_ID_PRESENT};
					end
				end
				JTP_SH_DR: begin
					// TDI is taken on the rising edge only.
					if (jtp_sel_bsr(q_r.ir)) begin
						q_nxt.bsr_sh = {q_r.tdi_s2, q_r.bsr_sh[CELLS-1:1]};
					end else if (jtp_sel_id(q_r.ir)) begin
						q_nxt.id_sh = {q_r.tdi_s2, q_r.id_sh[31:1]};
					end else begin
						q_nxt.skip = q_r.tdi_s2;
					end
				end
				JTP_UP_DR: begin
					// Preloaded or captured cells become the drive values.
					if (jtp_sel_bsr(q_r.ir)) begin
						q_nxt.bsr_upd = q_r.bsr_sh;
					end
				end
				JTP_CAP_IR: begin
					q_nxt.ir_sh = JTP_IR_CAPTURE;
				end
				JTP_SH_IR: begin
					q_nxt.ir_sh = {q_r.tdi_s2, q_r.ir_sh[3:1]};
				end
				JTP_UP_IR: begin
					q_nxt.ir = q_r.ir_sh;
				end
				default: begin
					q_nxt.skip = q_r.skip;
				end
			endcase
			q_nxt.st = jtp_next(q_r.st, q_r.tms_s2);
			// Loading on entry means the read code is active as soon as the port lands in reset.
			if (q_nxt.st == JTP_TLR) begin
				q_nxt.ir = JTP_IR_IDCODE;
			end
		end

		// Falling test clock: TDO changes here so the tester sees it stable at rise.
		if (tck_fall) begin
			q_nxt.tdo_oe_n = 1'b1;
			if (q_r.st == JTP_SH_IR) begin
				q_nxt.tdo      = q_r.ir_sh[0];
				q_nxt.tdo_oe_n = 1'b0;
			end else if (q_r.st == JTP_SH_DR) begin
				q_nxt.tdo_oe_n = 1'b0;
				if (jtp_sel_bsr(q_r.ir)) begin
					q_nxt.tdo = q_r.bsr_sh[0];
				end else if (jtp_sel_id(q_r.ir)) begin
					q_nxt.tdo = q_r.id_sh[0];
				end else begin
					// Reserved codes also fall back to the skip bit.
					q_nxt.tdo = q_r.skip;
				end
			end
		end

		// Functional controls follow the active instruction.
		q_nxt.highz      = (q_r.ir == JTP_IR_HIGHZ);
		q_nxt.from_cells = (q_r.ir == JTP_IR_CLAMP) || (q_r.ir == JTP_IR_EXTEST);
		q_nxt.core_rst   = (q_r.ir == JTP_IR_CORE_RST);

		// Register bus: one wait state, then ack for a single cycle.
		q_nxt.ack  = wb_req;
		q_nxt.rdat = 32'h0000_0000;
		if (wb_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == JTP_REG_CTRL)) begin
			q_nxt.variant = i_wb_dat[JTP_CTRL_VARIANT];
		end
		if (wb_req && !i_wb_we) begin
			case (i_wb_adr)
				JTP_REG_CTRL: begin
					q_nxt.rdat[JTP_CTRL_VARIANT] = q_r.variant;
				end
				JTP_REG_STATUS: begin
					q_nxt.rdat[3:0]  = q_r.ir;
					q_nxt.rdat[7:4]  = q_r.st;
					q_nxt.rdat[8]    = q_r.highz;
					q_nxt.rdat[9]    = q_r.from_cells;
					q_nxt.rdat[10]   = q_r.core_rst;
				end
				default: begin
					q_nxt.rdat = 32'h0000_0000;
				end
			endcase
		end

		// Synchronous reset puts the port in test logic reset.
		if (!i_rst_n) begin
			q_nxt          = '0;
			q_nxt.st       = JTP_TLR;
			q_nxt.ir       = JTP_IR_IDCODE;
			q_nxt.tdo_oe_n = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge i_clock) begin
		q_r <= q_nxt;
	end

	// Outputs come straight from the state register.
	assign o_tdo              = q_r.tdo;
	assign o_tdo_oe_n         = q_r.tdo_oe_n;
	assign o_cell_drive       = q_r.bsr_upd;
	assign o_out_from_cells   = q_r.from_cells;
	assign o_out_highz        = q_r.highz;
	assign o_core_logic_reset = q_r.core_rst;
	assign o_wb_dat           = q_r.rdat;
	assign o_wb_ack           = q_r.ack;

endmodule : jtp_tap
`default_nettype wire

//--- testbench/jtp_tap_sva.sv
// Checker of the bus handshake and of link output timing.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_sva #(
	parameter int unsigned CELLS = 16
) (
	// Clock, reset and link clock pin.
	input wire logic             i_clock,
	input wire logic             i_rst_n,
	input wire logic             i_tck,
	// Bus.
	input wire logic             i_wb_cyc,
	input wire logic             i_wb_stb,
	input wire logic             o_wb_ack,
	input wire logic [31:0]      o_wb_dat,
	// Link and pin control.
	input wire logic             o_tdo,
	input wire logic             o_tdo_oe_n,
	input wire logic [CELLS-1:0] o_cell_drive,
	input wire logic             o_out_highz,
	input wire logic             o_out_from_cells,
	input wire logic             o_core_logic_reset
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// The pin is synchronised, so every link output trails its pin edge by at least two clocks.
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	ack_time_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
	rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000) else $error("stray read data");
	flag_excl_a: assert property ($onehot0({o_out_highz, o_out_from_cells, o_core_logic_reset}))
		else $error("two flags high");
	tdo_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck, 2)) else $error("TDO off a fall");
	oe_fall_a: assert property ($changed(o_tdo_oe_n) |-> !$past(i_tck, 2)) else $error("enable off a fall");
	cell_rise_a: assert property ($changed(o_cell_drive) |-> $past(i_tck, 2))
		else $error("cells off a rise");
	flag_rise_a: assert property ($changed({o_out_highz, o_core_logic_reset}) |-> $past(i_tck, 2))
		else $error("flags off a rise");
endmodule : jtp_tap_sva
`default_nettype wire
bind jtp_tap jtp_tap_sva #(.CELLS(CELLS)) u_sva (.i_clock, .i_rst_n, .i_tck, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
	.o_wb_dat, .o_tdo, .o_tdo_oe_n, .o_cell_drive, .o_out_highz, .o_out_from_cells, .o_core_logic_reset);

//--- testbench/jtp_tester.sv
// Scan tester model that drives the link pins.
`timescale 1ns/1ps
`default_nettype none
module jtp_tester (
	// Clock and returned data.
	input  wire logic i_clock,
	input  wire logic i_tdo,
	// Link pins.
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi
);
	// The link clock rests low between frames.
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// Four clocks low, four high; TDO is read late in the high phase, where it is settled.
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (4) @(posedge i_clock);
		o_tck <= 1'b1;
		repeat (4) @(posedge i_clock);
		tdo = i_tdo;
		o_tck <= 1'b0;
	endtask : step
	// Five rises with TMS high reset the port, one low parks it in idle.
	task automatic to_idle();
		logic b;
		repeat (5) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask : to_idle
	// Idle to idle scan of n bits, LSB first; pause is never entered.
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = 32'h0000_0000;
		step(1'b1, 1'b0, b);
		if (ir) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask : scan
endmodule : jtp_tester
`default_nettype wire

//--- testbench/jtp_tap_tb.sv
// Bench for identification, instruction paths and the register bus.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_tb
	import jtp_pkg::*;
;
	localparam logic [31:0] PAT  = 32'hc3a5_96e1;
	localparam logic [15:0] RING = 16'hb4e1;
	localparam logic [31:0] ID_A = {JTP_ID_REVISION, JTP_ID_PART_A, JTP_ID_MAKER, JTP_ID_PRESENT};
	localparam logic [31:0] ID_B = {JTP_ID_REVISION, JTP_ID_PART_B, JTP_ID_MAKER, JTP_ID_PRESENT};
	// Only defined codes are loaded; bypass runs twice in the slot a reserved code would take.
	localparam logic [3:0]  CODES [8] = '{4'h0, 4'hf, 4'hb, 4'h7, 4'h4, 4'h8, 4'hf, 4'hc};
	logic        clock, rst_n, tck, tms, tdi, tdo, tdo_oe_n, wb_cyc, wb_stb, wb_we, wb_ack, bnd, hz, fc, cr;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat, wb_rdat, q, exp_dr;
	logic [3:0]  wb_sel, c;
	logic [2:0]  fl;
	logic [15:0] ring, cells;
	int          err_total, checks, cycles;
	jtp_tap #(.CELLS(16)) dut (.i_clock(clock), .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
		.o_tdo_oe_n(tdo_oe_n), .i_pin_ring(ring), .o_cell_drive(cells), .o_out_from_cells(fc), .o_out_highz(hz),
		.o_core_logic_reset(cr), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
		.i_wb_dat(wb_dat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack));
	jtp_tester u_tst (.i_clock(clock), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	// System clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// The run needs about 3800 clocks; a hang is cut short well beyond that.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle; the answer is awaited, never assumed.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, adr, dat, 4'hf};
		do @(posedge clock); while (wb_ack !== 1'b1);
		rd = wb_rdat;
		{wb_cyc, wb_stb} <= 2'b00;
		@(posedge clock);
	endtask : wb
	task automatic complete_run();
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// Main sequence.
	initial begin
		{rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = {12'h000, 32'h0000_0000, 4'hf};
		{ring, err_total, checks, cycles} = {RING, 96'h0};
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		u_tst.to_idle();
		chk({31'h0000_0000, tdo_oe_n}, 32'h0000_0001);
		u_tst.scan(1'b0, 32, PAT, q);
		chk(q, ID_A);
		wb(1'b1, JTP_REG_CTRL, 32'h0000_0001, q);
		wb(1'b0, JTP_REG_CTRL, 32'h0000_0000, q);
		chk(q, 32'h0000_0001);
		wb(1'b0, 8'h10, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		for (int k = 0; k < 8; k++) begin
			c = CODES[k];
			bnd = c == JTP_IR_EXTEST || c == JTP_IR_SAMPLE;
			fl = {c == JTP_IR_CORE_RST, c == JTP_IR_CLAMP || c == JTP_IR_EXTEST, c == JTP_IR_HIGHZ};
			u_tst.scan(1'b1, 4, {28'h000_0000, c}, q);
			chk(q, {28'h000_0000, JTP_IR_CAPTURE});
			wb(1'b0, JTP_REG_STATUS, 32'h0000_0000, q);
			chk(q, {21'h0, fl, JTP_RTI, c});
			chk({29'h0, cr, fc, hz}, {29'h0, fl});
			u_tst.scan(1'b0, 32, PAT, q);
			exp_dr = c == JTP_IR_IDCODE ? ID_B : bnd ? {PAT[15:0], RING} : {PAT[30:0], 1'b0};
			chk(q, exp_dr);
			if (bnd) chk({16'h0000, cells}, {16'h0000, PAT[31:16]});
		end
		// Park in test logic reset: the read code must already be active there.
		repeat (5) u_tst.step(1'b1, 1'b0, bnd);
		wb(1'b0, JTP_REG_STATUS, 32'h0000_0000, q);
		chk(q, {24'h00_0000, JTP_TLR, JTP_IR_IDCODE});
		u_tst.to_idle();
		wb(1'b1, JTP_REG_CTRL, 32'h0000_0000, q);
		u_tst.scan(1'b0, 32, PAT, q);
		chk(q, ID_A);
		complete_run();
	end
endmodule : jtp_tap_tb
`default_nettype wire
